// ===== design/slsm_params.svh
// constants of the serial lane sample mapper
`ifndef SLSM_PARAMS_SVH
`define SLSM_PARAMS_SVH
`define SLSM_FMT_W        5
`define SLSM_FMT_8_S16    5'h06
`define SLSM_FMT_8_D8     5'h07
`define SLSM_FMT_8_D16    5'h08
`define SLSM_FMT_15_D4_L4 5'h0a
`define SLSM_FMT_15_D4_L8 5'h0b
`define SLSM_FMT_15_D4_L16 5'h0c
`define SLSM_FMT_15_D8_L2 5'h0d
`define SLSM_FMT_15_D8_L4 5'h0e
`define SLSM_FMT_15_D8_L8 5'h0f
`define SLSM_FMT_15_D8_L16 5'h10
`define SLSM_FMT_12_S12   5'h13
`define SLSM_WORDS        16
`define SLSM_WORD_W       16
`define SLSM_LANES        16
`define SLSM_LANE_W       32
`define SLSM_SET_LANES    8
`define SLSM_FIFO_DEPTH   8
`endif

// ===== design/slsm_pkg.sv
// types shared by the lane mapper and its fifo
`include "slsm_params.svh"
package slsm_pkg;
  typedef enum logic [`SLSM_FMT_W-1:0] {
    SLSM_F8_S16     = `SLSM_FMT_8_S16,
    SLSM_F8_D8      = `SLSM_FMT_8_D8,
    SLSM_F8_D16     = `SLSM_FMT_8_D16,
    SLSM_F15_D4_L4  = `SLSM_FMT_15_D4_L4,
    SLSM_F15_D4_L8  = `SLSM_FMT_15_D4_L8,
    SLSM_F15_D4_L16 = `SLSM_FMT_15_D4_L16,
    SLSM_F15_D8_L2  = `SLSM_FMT_15_D8_L2,
    SLSM_F15_D8_L4  = `SLSM_FMT_15_D8_L4,
    SLSM_F15_D8_L8  = `SLSM_FMT_15_D8_L8,
    SLSM_F15_D8_L16 = `SLSM_FMT_15_D8_L16,
    SLSM_F12_S12    = `SLSM_FMT_12_S12
  } slsm_fmt_t;
  typedef logic [`SLSM_WORDS-1:0][`SLSM_WORD_W-1:0] slsm_words_t;
  typedef logic [`SLSM_LANES-1:0][`SLSM_LANE_W-1:0] slsm_lanes_t;
  typedef struct packed {
    logic [`SLSM_FMT_W-1:0] fmt;
    logic [`SLSM_WORDS-1:0] ovr;
    slsm_words_t            words;
  } slsm_entry_t;
endpackage

// ===== design/slsm_fifo_if.sv
// valid/ready carrier between the mapper and its fifo
interface slsm_fifo_if #(parameter int W = 8);
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;
  modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface

// ===== design/slsm_fifo.sv
// flop-based fifo with registered full and empty flags
module slsm_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic  clk_sys,
  input wire logic  rstn,
  slsm_fifo_if.fifo f
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  localparam logic [AW-1:0] LAST = AW'(D - 1);
  localparam logic [CW-1:0] FULL = CW'(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wptr;
    logic [AW-1:0]       rptr;
    logic [CW-1:0]       cnt;
    logic                ready;
    logic                avail;
  } slsm_fifo_st_t;

  slsm_fifo_st_t s_q;
  slsm_fifo_st_t s_d;
  logic          push;
  logic          pop;

  assign push = f.wr_valid && s_q.ready;
  assign pop = f.rd_ready && s_q.avail;
  assign f.wr_ready = s_q.ready;
  assign f.rd_valid = s_q.avail;
  assign f.rd_data = s_q.mem[s_q.rptr];

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wptr] = f.wr_data;
      s_d.wptr = (s_q.wptr == LAST) ? '0 : s_q.wptr + 1'b1;
    end
    if (pop) begin
      s_d.rptr = (s_q.rptr == LAST) ? '0 : s_q.rptr + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
    s_d.ready = (s_d.cnt != FULL);
    s_d.avail = (s_d.cnt != '0);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ===== design/slsm_mapper.sv
// sample-to-lane mapper for 8-, 12- and 15-bit link formats
// Operation
// [R1] 8-bit single 16-lane: sample 2k on first-set lane k, 2k+1 on second-set lane k.
// [R2] 8-bit dual 8-lane: channel one sample k first-set lane k, channel two second-set.
// [R3] 8-bit dual 16-lane: samples 0-7 of each channel on lanes 0-7 of its set.
// [R4] 15-bit dec-4 4-lane: I and Q words of each channel on lanes 0,1 of its set.
// [R5] 15-bit dec-4 8-lane: two I words lanes 0-1, two Q words lanes 2-3.
// [R6] 15-bit dec-4 16-lane: four I words lanes 0-3, four Q words lanes 4-7.
// [R7] 15-bit dec-8 2-lane: lane 0 carries I in octets 0-1, Q in 2-3.
// [R8] 15-bit dec-8 4-lane uses the dec-4 4-lane assignment.
// [R9] 15-bit dec-8 8-lane: two I words lanes 0-1, two Q words lanes 2-3.
// [R10] 15-bit dec-8 16-lane: four I words lanes 0-3, four Q words lanes 4-7.
// [R11] 12-bit single 12-lane: four samples msb-first over three lanes, evens first set.
// [R12] decimated lane word: 15-bit sample in upper bits, over-range flag in bit 0.
// [R13] receiver must be set to the same link format to unpack lanes.
`include "slsm_params.svh"

module slsm_mapper #(
  parameter int FIFO_DEPTH = `SLSM_FIFO_DEPTH
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rstn,
  input  wire logic [`SLSM_FMT_W-1:0]  link_format_select,
  input  wire logic                    in_valid,
  output logic                         in_ready,
  input  wire slsm_pkg::slsm_words_t   in_samples,
  input  wire logic [`SLSM_WORDS-1:0]  in_overrange,
  output slsm_pkg::slsm_lanes_t        lane_data,
  output logic                         lane_valid,
  input  wire logic                    lane_ready,
  output logic [`SLSM_FMT_W-1:0]       lane_format,
  output logic [`SLSM_LANES-1:0]       lane_active,
  output logic [2:0]                   lane_octets,
  output logic                         format_error
);
  localparam int EW = $bits(slsm_pkg::slsm_entry_t);

  typedef struct packed {
    slsm_pkg::slsm_lanes_t  lanes;
    logic                   valid;
    logic [`SLSM_FMT_W-1:0] fmt;
    logic [`SLSM_LANES-1:0] active;
    logic [2:0]             octets;
    logic                   err;
  } slsm_map_st_t;

  slsm_map_st_t          s_q;
  slsm_map_st_t          s_d;
  slsm_pkg::slsm_entry_t ent_in;
  slsm_pkg::slsm_entry_t ent_out;
  logic                  take;
  slsm_pkg::slsm_words_t dword;
  logic [95:0]           pk_even;
  logic [95:0]           pk_odd;

  slsm_fifo_if #(.W(EW)) fq ();

  slsm_fifo #(
    .W (EW),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .f       (fq)
  );

  // the format travels with each frame through the fifo
  always_comb begin
    ent_in.fmt = link_format_select;
    ent_in.ovr = in_overrange;
    ent_in.words = in_samples;
  end

  // push side straight through; in_ready is the fifo's registered flag
  assign fq.wr_valid = in_valid;
  assign fq.wr_data = ent_in;
  assign ent_out = fq.rd_data;
  // output stage reloads when empty or when its frame is taken
  assign take = !s_q.valid || lane_ready;
  assign fq.rd_ready = take;
  assign in_ready = fq.wr_ready;

  // per word: flagged 15-bit word, and 12-bit packing msb first, evens apart from odds
  for (genvar g = 0; g < `SLSM_WORDS; g++) begin : g_word
    assign dword[g] = {ent_out.words[g][14:0], ent_out.ovr[g]}; // R12
    if (g % 2 == 0) begin : g_even
      assign pk_even[95-6*g -: 12] = ent_out.words[g][11:0]; // R11
    end else begin : g_odd
      assign pk_odd[95-6*(g-1) -: 12] = ent_out.words[g][11:0]; // R11
    end
  end

  // one frame of lane words, left-justified, octet 0 in bits 31:24
  function automatic slsm_pkg::slsm_lanes_t slsm_map(
    input logic [`SLSM_FMT_W-1:0] fmt,
    input slsm_pkg::slsm_words_t  w,
    input slsm_pkg::slsm_words_t  dw,
    input logic [95:0]            pe,
    input logic [95:0]            po
  );
    slsm_pkg::slsm_lanes_t l;
    l = '0;
    case (fmt)
      `SLSM_FMT_8_S16: begin
        for (int k = 0; k < 8; k++) begin
          l[k] = {w[2*k][7:0], 24'h0}; // R1
          l[k+8] = {w[2*k+1][7:0], 24'h0}; // R1
        end
      end
      `SLSM_FMT_8_D8: begin
        for (int k = 0; k < 4; k++) begin
          l[k] = {w[k][7:0], 24'h0}; // R2
          l[k+8] = {w[k+8][7:0], 24'h0}; // R2
        end
      end
      `SLSM_FMT_8_D16: begin
        for (int k = 0; k < `SLSM_LANES; k++) begin
          l[k] = {w[k][7:0], 24'h0}; // R3
        end
      end
      `SLSM_FMT_15_D4_L4, `SLSM_FMT_15_D8_L4: begin
        for (int c = 0; c < 2; c++) begin
          l[8*c] = {dw[8*c], 16'h0}; // R4 R8
          l[8*c+1] = {dw[8*c+4], 16'h0}; // R4 R8
        end
      end
      `SLSM_FMT_15_D4_L8, `SLSM_FMT_15_D8_L8: begin
        for (int c = 0; c < 2; c++) begin
          for (int k = 0; k < 2; k++) begin
            l[8*c+k] = {dw[8*c+k], 16'h0}; // R5 R9
            l[8*c+k+2] = {dw[8*c+k+4], 16'h0}; // R5 R9
          end
        end
      end
      `SLSM_FMT_15_D4_L16, `SLSM_FMT_15_D8_L16: begin
        for (int k = 0; k < `SLSM_LANES; k++) begin
          l[k] = {dw[k], 16'h0}; // R6 R10
        end
      end
      `SLSM_FMT_15_D8_L2: begin
        l[0] = {dw[0], dw[4]}; // R7
        l[8] = {dw[8], dw[12]}; // R7
      end
      `SLSM_FMT_12_S12: begin
        for (int k = 0; k < 6; k++) begin
          l[k] = {pe[95-16*k -: 16], 16'h0}; // R11
          l[k+8] = {po[95-16*k -: 16], 16'h0}; // R11
        end
      end
      default: begin
        l = '0;
      end
    endcase
    return l;
  endfunction

  // next output frame and its side information
  always_comb begin
    s_d = s_q;
    if (lane_ready) begin
      s_d.valid = 1'b0;
    end
    if (take && fq.rd_valid) begin
      s_d.valid = 1'b1;
      s_d.fmt = ent_out.fmt;
      s_d.lanes = slsm_map(ent_out.fmt, ent_out.words, dword, pk_even, pk_odd);
      s_d.err = 1'b0;
      // lane shape: lanes in use and octets per lane frame
      case (ent_out.fmt)
        `SLSM_FMT_8_S16, `SLSM_FMT_8_D16: begin
          s_d.active = 16'hffff;
          s_d.octets = 3'h1;
        end
        `SLSM_FMT_8_D8: begin
          s_d.active = 16'h0f0f;
          s_d.octets = 3'h1;
        end
        `SLSM_FMT_15_D4_L4, `SLSM_FMT_15_D8_L4: begin
          s_d.active = 16'h0303;
          s_d.octets = 3'h2;
        end
        `SLSM_FMT_15_D4_L8, `SLSM_FMT_15_D8_L8: begin
          s_d.active = 16'h0f0f;
          s_d.octets = 3'h2;
        end
        `SLSM_FMT_15_D4_L16, `SLSM_FMT_15_D8_L16: begin
          s_d.active = 16'hffff;
          s_d.octets = 3'h2;
        end
        `SLSM_FMT_15_D8_L2: begin
          s_d.active = 16'h0101;
          s_d.octets = 3'h4;
        end
        `SLSM_FMT_12_S12: begin
          s_d.active = 16'h3f3f;
          s_d.octets = 3'h2;
        end
        default: begin
          // unknown format: frame goes out all zero, flagged
          s_d.active = 16'h0000;
          s_d.octets = 3'h0;
          s_d.err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // every output but in_ready straight from the stage register
  assign lane_data = s_q.lanes;
  assign lane_valid = s_q.valid;
  assign lane_format = s_q.fmt;
  assign lane_active = s_q.active;
  assign lane_octets = s_q.octets;
  assign format_error = s_q.err;
endmodule

// ===== sim/slsm_sink.sv
// lane receiver model with prompt, slow and stalled acceptance
module slsm_sink (
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic [1:0] mode,
  output logic           lane_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_q;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      cnt_q <= 2'h0;
    else
      cnt_q <= #1 cnt_q + 2'h1;
  end
  // mode 0 prompt, 1 ready one cycle in four, 2 stalled
  assign lane_ready = (mode == 2'h0) || (mode == 2'h1 && cnt_q == 2'h3);
endmodule

// ===== sim/slsm_mapper_sva.sv
// port assertions for the lane mapper
`include "slsm_params.svh"
module slsm_mapper_sva (
  input wire logic                   clk_sys,
  input wire logic                   rstn,
  input wire logic                   in_ready,
  input wire slsm_pkg::slsm_lanes_t  lane_data,
  input wire logic                   lane_valid,
  input wire logic                   lane_ready,
  input wire logic [`SLSM_FMT_W-1:0] lane_format,
  input wire logic [`SLSM_LANES-1:0] lane_active,
  input wire logic [2:0]             lane_octets,
  input wire logic                   format_error
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic             hold;
  logic [15:0]      used;
  assign hold = lane_valid && !lane_ready;
  always_comb begin
    for (int k = 0; k < 16; k++)
      used[k] = |lane_data[k];
  end
  AST_HOLD: assert property (hold |=> lane_valid && $stable(lane_data) && $stable(lane_format))
    else $error("frame changed while stalled");
  AST_FULL: assert property ($fell(in_ready) |-> lane_valid && $past(hold))
    else $error("full without stalled output");
  AST_IDLE_LANES: assert property (lane_valid |-> (used & ~lane_active) == 16'h0)
    else $error("inactive lane not zero");
  AST_ERR: assert property (lane_valid && format_error |-> used == 16'h0 && lane_octets == 3'h0)
    else $error("bad format frame not empty");
  AST_S16: assert property (lane_valid && lane_format == `SLSM_FMT_8_S16 |->
    lane_active == 16'hffff && lane_octets == 3'h1) else $error("single 16 lane shape");
  AST_D8: assert property (lane_valid && lane_format == `SLSM_FMT_8_D8 |->
    lane_active == 16'h0f0f && lane_octets == 3'h1) else $error("dual 8 lane shape");
  AST_D16: assert property (lane_valid && lane_format == `SLSM_FMT_8_D16 |->
    lane_active == 16'hffff && lane_octets == 3'h1) else $error("dual 16 lane shape");
  AST_L4: assert property (lane_valid && lane_format inside {5'h0a, 5'h0e} |->
    lane_active == 16'h0303 && lane_octets == 3'h2) else $error("4 lane shape");
  AST_L8: assert property (lane_valid && lane_format inside {5'h0b, 5'h0f} |->
    lane_active == 16'h0f0f && lane_octets == 3'h2) else $error("8 lane shape");
  AST_L16: assert property (lane_valid && lane_format inside {5'h0c, 5'h10} |->
    lane_active == 16'hffff && lane_octets == 3'h2) else $error("16 lane shape");
  AST_L2: assert property (lane_valid && lane_format == `SLSM_FMT_15_D8_L2 |->
    lane_active == 16'h0101 && lane_octets == 3'h4) else $error("2 lane shape");
  AST_S12: assert property (lane_valid && lane_format == `SLSM_FMT_12_S12 |->
    lane_active == 16'h3f3f && lane_octets == 3'h2) else $error("12 lane shape");
endmodule
bind slsm_mapper slsm_mapper_sva u_sva (.*);

// ===== sim/testbench.sv
// random and corner-case bench for the lane mapper
`include "slsm_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rstn = 0, in_valid = 0, in_ready, lane_valid, lane_ready, format_error;
  logic [4:0]            fmt = 0, lane_format;
  logic [15:0]           ov = 0, lf = 16'h91c1;
  logic [1:0]            mode = 0;
  slsm_pkg::slsm_words_t w = '0;
  slsm_pkg::slsm_lanes_t lane_data;
  logic [15:0]           lane_active;
  logic [2:0]            lane_octets;
  logic [536:0]          exq[$];
  logic [536:0]          got;
  logic [4:0] codes[12] = '{5'h06, 5'h07, 5'h08, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f,
                            5'h10, 5'h13, 5'h1f};
  int num_errors = 0, n_checks = 0, n;
  bit ok, abort;
  always #50 clk_sys = ~clk_sys;
  slsm_mapper dut (.clk_sys(clk_sys), .rstn(rstn), .link_format_select(fmt),
    .in_valid(in_valid), .in_ready(in_ready), .in_samples(w), .in_overrange(ov),
    .lane_data(lane_data), .lane_valid(lane_valid), .lane_ready(lane_ready),
    .lane_format(lane_format), .lane_active(lane_active), .lane_octets(lane_octets),
    .format_error(format_error));
  slsm_sink sink (.clk_sys(clk_sys), .rstn(rstn), .mode(mode), .lane_ready(lane_ready));
  function logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  function automatic logic [536:0] exp_frame(logic [4:0] f, slsm_pkg::slsm_words_t x,
                                             logic [15:0] o);
    slsm_pkg::slsm_lanes_t l;
    logic [1:0][95:0]      e;
    int                    n;
    logic [15:0]           a;
    logic [2:0]            oc;
    l = '0;
    e = '0;
    n = (f % 4 == 2) ? 1 : (f % 4 == 3) ? 2 : 4;
    for (int k = 0; k < 16; k++)
      e[k % 2][95 - 12 * (k / 2) -: 12] = x[k][11:0];
    for (int k = 0; k < 16; k++) begin
      case (f)
        5'h06: l[k % 2 * 8 + k / 2][31:24] = x[k][7:0];
        5'h07: if (k % 8 < 4) l[k][31:24] = x[k][7:0];
        5'h08: l[k][31:24] = x[k][7:0];
        5'h0d: if (k % 4 == 0) l[k / 8 * 8][31 - k % 8 * 4 -: 16] = {x[k][14:0], o[k]};
        5'h0a, 5'h0b, 5'h0c, 5'h0e, 5'h0f, 5'h10: if (k % 4 < n)
          l[k / 8 * 8 + k / 4 % 2 * n + k % 4][31:16] = {x[k][14:0], o[k]};
        5'h13: if (k % 8 < 6) l[k][31:16] = e[k / 8][95 - 16 * (k % 8) -: 16];
        default: ;
      endcase
    end
    case (f)
      5'h06, 5'h08, 5'h0c, 5'h10: a = 16'hffff;
      5'h07, 5'h0b, 5'h0f: a = 16'h0f0f;
      5'h0a, 5'h0e: a = 16'h0303;
      5'h0d: a = 16'h0101;
      5'h13: a = 16'h3f3f;
      default: a = 16'h0000;
    endcase
    oc = (f inside {[5'h06:5'h08]}) ? 3'h1 : (f == 5'h0d) ? 3'h4 : (a != 16'h0) ? 3'h2 : 3'h0;
    return {f, a == 16'h0, oc, a, l};
  endfunction
  task check(input logic [536:0] seen, input logic [536:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task push(input logic [4:0] f, input int lim);
    int t;
    if (abort) begin
      ok = 0;
      return;
    end
    fmt = f;
    for (int k = 0; k < 16; k++)
      w[k] = rnd();
    ov = rnd();
    in_valid = 1;
    t = 0;
    // in_ready read off the edge: the value the next edge will sample
    do begin
      ok = in_ready;
      @(posedge clk_sys);
      #1;
      t++;
    end while (!ok && t < lim);
    if (ok)
      exq.push_back(exp_frame(f, w, ov));
    else if (lim > 1) begin
      check(0, 1);
      abort = 1;
    end
  endtask
  task drain();
    in_valid = 0;
    mode = 0;
    for (int t = 0; t < 500 && exq.size() > 0; t++)
      @(posedge clk_sys);
    #1;
    check(exq.size(), 0);
  endtask
  // receiver decodes with the format carried beside the frame
  // looked at mid-cycle, where the handshake of the coming edge is settled
  always @(negedge clk_sys) begin
    if (rstn && lane_valid && lane_ready) begin
      check(exq.size() > 0, 1);
      got = {lane_format, format_error, lane_octets, lane_active, lane_data};
      if (exq.size() > 0)
        check(got, exq.pop_front());
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    #1 rstn = 1;
    check({in_ready, lane_valid}, 2'h2);
    @(posedge clk_sys);
    #1;
    for (int i = 0; i < 12; i++)
      push(codes[i], 400);
    drain();
    $display("every format back to back done");
    mode = 1;
    repeat (60) push(codes[rnd() % 12], 400);
    drain();
    $display("random frames with slow receiver done");
    mode = 2;
    n = 0;
    do begin
      push(codes[n % 12], 1);
      n += ok;
    end while (ok && n < 20);
    check(n, `SLSM_FIFO_DEPTH + 1);
    drain();
    $display("fill until refused and drain done");
    print_verdict();
  end
endmodule
